// >>> design/fwpm_ctrl.sv
// The address-and-strobe port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module fwpm_ctrl #(
   parameter int DE_LOW_CYC = fwpm_pkg::DE_LOW_CYC,
   parameter int BIAS_TO_CYC = fwpm_pkg::BIAS_TO_CYC
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic drive_en_pin,
   input wire logic wake_pin,
   input wire logic [5:0] pwm_pin,
   input wire logic [fwpm_pkg::FAULT_W-1:0] fault_cond,
   input wire logic vdd_above_shutdown,
   input wire logic charge_pump_active,
   input wire logic bias_ready_flag,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic fault_out,
   output logic fault_oe_n,
   output logic [5:0] gate_drive,
   output logic amp_en,
   output logic logic_supply_ldo,
   output logic gate_bias_supply,
   output logic gate_bias_from_pump,
   output logic irq
);

   // ----------------------------------------------------------------
   // pin conditioning
   // ----------------------------------------------------------------
   logic de_lvl;
   logic de_rise;
   logic de_long;
   logic wake_ok;
   logic [fwpm_pkg::FAULT_W+8:0] meta;
   logic [fwpm_pkg::FAULT_W+8:0] sync;

   fwpm_pin_watch #(.THRESH(DE_LOW_CYC)) u_de_watch (
      .clk(clk),
      .nrst(nrst),
      .pin(drive_en_pin),
      .level(de_lvl),
      .rise(de_rise),
      .long_low(de_long),
      .armed_rise()
   );

   fwpm_pin_watch #(.THRESH(fwpm_pkg::WAKE_SETUP_CYC)) u_wake_watch (
      .clk(clk),
      .nrst(nrst),
      .pin(wake_pin),
      .level(),
      .rise(),
      .long_low(),
      .armed_rise(wake_ok)
   );

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         meta <= '0;
         sync <= '0;
      end else begin
         meta <= {pwm_pin, bias_ready_flag, charge_pump_active, vdd_above_shutdown, fault_cond};
         sync <= meta;
      end
   end

   wire [fwpm_pkg::FAULT_W-1:0] fault_s = sync[fwpm_pkg::FAULT_W-1:0];
   wire vdd_ok = sync[fwpm_pkg::FAULT_W];
   wire cp_s = sync[fwpm_pkg::FAULT_W+1];
   wire bias_rdy_s = sync[fwpm_pkg::FAULT_W+2];
   wire [5:0] pwm_s = sync[fwpm_pkg::FAULT_W+8:fwpm_pkg::FAULT_W+3];
   wire fault_active = |fault_s;

   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------
   logic [7:0] config_reg_zero;
   logic [7:0] irq_enable;
   logic [fwpm_pkg::IRQ_W-1:0] irq_status;
   wire amp_standby_off = config_reg_zero[fwpm_pkg::CFG_AMP_STANDBY_OFF];
   wire deep_idle = config_reg_zero[fwpm_pkg::CFG_DEEP_IDLE];
   wire wr_cfg = reg_wr && (reg_addr == fwpm_pkg::ADDR_CONFIG_REG_ZERO);
   wire wr_ien = reg_wr && (reg_addr == fwpm_pkg::ADDR_IRQ_ENABLE);
   wire wr_iclr = reg_wr && (reg_addr == fwpm_pkg::ADDR_IRQ_CLEAR);

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         config_reg_zero <= fwpm_pkg::CONFIG_RESET;
         irq_enable <= fwpm_pkg::IRQ_ENABLE_RESET;
      end else begin
         if (wr_cfg) begin
            config_reg_zero <= reg_wdata;
         end
         if (wr_ien) begin
            irq_enable <= reg_wdata;
         end
      end
   end

   // ----------------------------------------------------------------
   // mode state machine
   // ----------------------------------------------------------------
   fwpm_pkg::fwpm_state_t state;
   fwpm_pkg::fwpm_state_t next_state;
   logic [fwpm_pkg::CNT_W-1:0] bias_cnt;
   logic [fwpm_pkg::CNT_W-1:0] next_bias_cnt;
   localparam logic [fwpm_pkg::CNT_W-1:0] BIAS_LAST = fwpm_pkg::CNT_W'(BIAS_TO_CYC - 1);
   wire bias_timeout = (state == fwpm_pkg::FWPM_BIAS) && (bias_cnt == BIAS_LAST) && !bias_rdy_s;
   // long-low flag lingers one cycle after the pin rises; only a still-low pin may idle
   wire de_idle = de_long && !de_lvl;
   fwpm_pkg::fwpm_state_t idle_target;
   assign idle_target = deep_idle ? fwpm_pkg::FWPM_SLEEP : fwpm_pkg::FWPM_STANDBY;

   always_comb begin
      next_state = state;
      case (state)
         fwpm_pkg::FWPM_POR: begin
            next_state = fwpm_pkg::FWPM_LDO;
         end
         fwpm_pkg::FWPM_LDO: begin
            if (vdd_ok) begin
               next_state = de_lvl ? fwpm_pkg::FWPM_BIAS : fwpm_pkg::FWPM_STANDBY;
            end
         end
         fwpm_pkg::FWPM_STANDBY: begin
            if (de_lvl) begin
               next_state = fwpm_pkg::FWPM_BIAS;
            end else if (de_idle && deep_idle) begin
               next_state = fwpm_pkg::FWPM_SLEEP;
            end
         end
         fwpm_pkg::FWPM_BIAS: begin
            if (de_idle) begin
               next_state = idle_target;
            end else if (de_lvl && (bias_rdy_s || bias_timeout)) begin
               next_state = fwpm_pkg::FWPM_ACTIVE;
            end
         end
         fwpm_pkg::FWPM_ACTIVE: begin
            if (de_idle) begin
               next_state = idle_target;
            end
         end
         fwpm_pkg::FWPM_SLEEP: begin
            if (wake_ok) begin
               next_state = fwpm_pkg::FWPM_LDO;
            end
         end
         default: begin
            next_state = fwpm_pkg::FWPM_POR;
         end
      endcase
   end

   assign next_bias_cnt = (state == fwpm_pkg::FWPM_BIAS) ? bias_cnt + 1'b1 : '0;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state <= fwpm_pkg::FWPM_POR;
         bias_cnt <= '0;
      end else begin
         state <= next_state;
         bias_cnt <= next_bias_cnt;
      end
   end

   // ----------------------------------------------------------------
   // fault latch and power-up hold
   // ----------------------------------------------------------------
   logic fault_latch;
   logic por_hold;
   wire fault_clr = de_rise && !fault_active;
   wire next_por_hold = por_hold && !(state == fwpm_pkg::FWPM_LDO && next_state != fwpm_pkg::FWPM_LDO);
   wire next_fault_latch = fault_active | (fault_latch & ~fault_clr);

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         fault_latch <= 1'b0;
         por_hold <= 1'b1;
         fault_out <= 1'b0;
         fault_oe_n <= 1'b0;
      end else begin
         fault_latch <= next_fault_latch;
         por_hold <= next_por_hold;
         fault_out <= 1'b0;
         fault_oe_n <= ~(next_fault_latch | next_por_hold);
      end
   end

   // ----------------------------------------------------------------
   // supply, amplifier and gate outputs
   // ----------------------------------------------------------------
   wire gate_ok = (state == fwpm_pkg::FWPM_ACTIVE) && de_lvl && !fault_active;
   wire next_amp_en = !(!de_lvl && amp_standby_off);
   wire next_ldo = (state != fwpm_pkg::FWPM_SLEEP) && vdd_ok;
   wire next_bias_en = (state == fwpm_pkg::FWPM_BIAS) || (state == fwpm_pkg::FWPM_ACTIVE);

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         gate_drive <= 6'h00;
         amp_en <= 1'b0;
         logic_supply_ldo <= 1'b0;
         gate_bias_supply <= 1'b0;
         gate_bias_from_pump <= 1'b0;
      end else begin
         gate_drive <= gate_ok ? pwm_s : 6'h00;
         amp_en <= next_amp_en;
         logic_supply_ldo <= next_ldo;
         gate_bias_supply <= next_bias_en;
         gate_bias_from_pump <= cp_s;
      end
   end

   // ----------------------------------------------------------------
   // interrupts
   // ----------------------------------------------------------------
   wire [fwpm_pkg::IRQ_W-1:0] irq_event = {
      bias_timeout,
      (next_state == fwpm_pkg::FWPM_SLEEP) && (state != fwpm_pkg::FWPM_SLEEP),
      (state == fwpm_pkg::FWPM_SLEEP) && wake_ok,
      fault_active && !fault_latch
   };
   wire [fwpm_pkg::IRQ_W-1:0] irq_clr = wr_iclr ? reg_wdata[fwpm_pkg::IRQ_W-1:0] : '0;
   wire [fwpm_pkg::IRQ_W-1:0] next_irq_status = irq_event | (irq_status & ~irq_clr);

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         irq_status <= '0;
         irq <= 1'b0;
      end else begin
         irq_status <= next_irq_status;
         irq <= |(next_irq_status & irq_enable[fwpm_pkg::IRQ_W-1:0]);
      end
   end

   // ----------------------------------------------------------------
   // register read port
   // ----------------------------------------------------------------
   wire [7:0] mode_status = {1'b0, cp_s, next_ldo, fault_active, fault_latch, state};
   logic [7:0] rd_mux;
   always_comb begin
      case (reg_addr)
         fwpm_pkg::ADDR_CONFIG_REG_ZERO: rd_mux = config_reg_zero;
         fwpm_pkg::ADDR_MODE_STATUS: rd_mux = mode_status;
         fwpm_pkg::ADDR_IRQ_STATUS: rd_mux = {{(8 - fwpm_pkg::IRQ_W){1'b0}}, irq_status};
         fwpm_pkg::ADDR_IRQ_ENABLE: rd_mux = irq_enable;
         default: rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= reg_rd ? rd_mux : 8'h00;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   localparam int GATE_OFF = fwpm_pkg::GATE_OFF_CYC;
   sequence s_fault_seen;
      fault_active ##1 !fault_active;
   endsequence
   sequence s_de_toggle;
      !de_lvl ##1 de_lvl;
   endsequence

   AST_FAULT_PIN: assert property (fault_active |=> !fault_oe_n)
      else $error("fault active but pin released");
   AST_FAULT_STICKY: assert property (s_fault_seen ##0 !de_rise |=> fault_latch && !fault_oe_n)
      else $error("fault latch lost without enable edge");
   AST_FAULT_CLEAR: assert property (s_de_toggle ##0 (!fault_active && !por_hold) |=> !fault_latch)
      else $error("enable rising edge did not clear latch");
   AST_POR_HOLD: assert property ((state == fwpm_pkg::FWPM_POR || next_state == fwpm_pkg::FWPM_LDO) && por_hold
      |=> !fault_oe_n)
      else $error("fault pin released before supply state done");
   AST_AMP_OFF: assert property (!de_lvl && amp_standby_off |=> !amp_en)
      else $error("amplifier enable wrong");
   AST_AMP_ON: assert property (de_lvl || !amp_standby_off |=> amp_en)
      else $error("amplifier disabled while allowed");
   AST_WAKE_EXIT: assert property (state == fwpm_pkg::FWPM_SLEEP && wake_ok |=> state == fwpm_pkg::FWPM_LDO)
      else $error("armed wake edge did not leave sleep");
   AST_SLEEP_STAY: assert property (state == fwpm_pkg::FWPM_SLEEP && !wake_ok |=> state == fwpm_pkg::FWPM_SLEEP)
      else $error("sleep left without armed wake edge");
   AST_LDO_OFF: assert property (state == fwpm_pkg::FWPM_SLEEP |=> !logic_supply_ldo)
      else $error("logic supply on in sleep");
   AST_BIAS_SRC: assert property (cp_s |=> gate_bias_from_pump)
      else $error("bias source not pump");
   AST_GATE_OFF: assert property ($fell(drive_en_pin) |-> ##[1:GATE_OFF] (gate_drive == 6'h00))
      else $error("gates not low in time");
   AST_NO_EARLY_IDLE: assert property (state == fwpm_pkg::FWPM_ACTIVE && !de_long |=> state != fwpm_pkg::FWPM_SLEEP
      && state != fwpm_pkg::FWPM_STANDBY)
      else $error("idle entered before timeout");
   AST_IDLE_SEL: assert property (state == fwpm_pkg::FWPM_ACTIVE && de_long && deep_idle
      |=> state == fwpm_pkg::FWPM_SLEEP)
      else $error("deep idle did not select sleep");
   AST_BIAS_EXIT: assert property (state == fwpm_pkg::FWPM_BIAS && de_lvl && (bias_rdy_s || bias_timeout)
      |=> state == fwpm_pkg::FWPM_ACTIVE)
      else $error("bias state not left");

endmodule // fwpm_ctrl
`default_nettype wire

// >>> design/fwpm_pkg.sv
// Function
// - any active fault pulls the fault pin low and sets the fault latch
// - fault pin stays low until fault ends and drive enable rises; that edge clears latch
// - after power-up the fault pin stays low until the logic supply state completes
// - amplifiers off only while drive enable is low and amp standby-off bit set
// - sleep exits on wake rising edge after wake held low for setup time
// - logic supply regulator on when not sleeping and supply above shutdown level
// - gate bias supply fed from charge pump when active, else main supply
// - drive enable falling forces all gate outputs low within 100 ns
// - standby or sleep entered only after drive enable low for 1 ms, except standby straight from the supply state when enable is low
// - on that timeout enter sleep if deep idle bit set, else standby
// - bias charging state exits on bias ready flag or after 15 ms
package fwpm_pkg;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 8000;
   localparam int GATE_OFF_TIME_NS = 100;
   localparam int GATE_OFF_CYC = (GATE_OFF_TIME_NS * 1000) / CLK_PERIOD_PS;
   localparam int DE_LOW_TIME_US = 1000;
   localparam int DE_LOW_CYC = (DE_LOW_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int BIAS_TO_TIME_MS = 15;
   localparam longint BIAS_TO_PROD = longint'(BIAS_TO_TIME_MS) * 64'd1000000000;
   localparam int BIAS_TO_CYC = int'(BIAS_TO_PROD / CLK_PERIOD_PS);
   localparam int WAKE_SETUP_TIME_US = 10;
   localparam int WAKE_SETUP_CYC = (WAKE_SETUP_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int CNT_W = 21;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_CONFIG_REG_ZERO = 8'h00;
   localparam logic [7:0] ADDR_MODE_STATUS = 8'h01;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h02;
   localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h03;
   localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h04;
   localparam logic [7:0] CONFIG_RESET = 8'h00;
   localparam logic [7:0] IRQ_ENABLE_RESET = 8'h00;
   localparam int CFG_AMP_STANDBY_OFF = 0;
   localparam int CFG_DEEP_IDLE = 1;
   localparam int ST_MODE_LSB = 0;
   localparam int ST_FAULT_LATCH = 3;
   localparam int ST_FAULT_ACTIVE = 4;
   localparam int ST_LDO_EN = 5;
   localparam int ST_BIAS_FROM_PUMP = 6;
   localparam int IRQ_FAULT = 0;
   localparam int IRQ_WAKE = 1;
   localparam int IRQ_SLEEP = 2;
   localparam int IRQ_BIAS_TIMEOUT = 3;
   localparam int IRQ_W = 4;
   localparam int FAULT_W = 4;

   // ----------------------------------------------------------------
   // mode states, gray along power-up path
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      FWPM_POR = 3'h0,
      FWPM_LDO = 3'h1,
      FWPM_STANDBY = 3'h3,
      FWPM_BIAS = 3'h2,
      FWPM_ACTIVE = 3'h6,
      FWPM_SLEEP = 3'h7
   } fwpm_state_t;

endpackage

// >>> design/fwpm_pin_watch.sv
`timescale 1ns/1ps
`default_nettype none
module fwpm_pin_watch #(
   parameter int THRESH = 1
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic pin,
   output logic level,
   output logic rise,
   output logic long_low,
   output logic armed_rise
);

   // ----------------------------------------------------------------
   // synchroniser and low-time counter
   // ----------------------------------------------------------------
   logic meta;
   logic level_d;
   logic [fwpm_pkg::CNT_W-1:0] low_cnt;
   logic [fwpm_pkg::CNT_W-1:0] next_low_cnt;
   localparam logic [fwpm_pkg::CNT_W-1:0] THRESH_W = fwpm_pkg::CNT_W'(THRESH);

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         meta <= 1'b0;
         level <= 1'b0;
         level_d <= 1'b0;
         low_cnt <= '0;
      end else begin
         meta <= pin;
         level <= meta;
         level_d <= level;
         low_cnt <= next_low_cnt;
      end
   end

   assign next_low_cnt = level ? '0 : (long_low ? low_cnt : low_cnt + 1'b1);
   assign long_low = (low_cnt == THRESH_W);
   assign rise = level & ~level_d;
   assign armed_rise = rise & long_low;

   AST_SYNC_DELAY: assert property (@(posedge clk) disable iff (!nrst)
      ##2 level == $past(pin, 2)) else $error("pin not seen two cycles later");

endmodule // fwpm_pin_watch
`default_nettype wire

// >>> verif/fwpm_host.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// host model driving the enable and wake pins
// ----------------------------------------------------------------
module fwpm_host (
   input wire logic clk,
   input wire logic nrst,
   input wire logic de_req,
   input wire logic wake_req,
   output logic drive_en_pin,
   output logic wake_pin
);
   // pins rest low like their pull-downs while the host is in reset
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         drive_en_pin <= 1'b0;
         wake_pin <= 1'b0;
      end else begin
         drive_en_pin <= de_req;
         wake_pin <= wake_req;
      end
   end
endmodule // fwpm_host
`default_nettype wire

// >>> verif/fault_wake_power_mode_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
module fault_wake_power_mode_ctrl_bench;
   localparam int DE_LOW = 20;
   localparam int BIAS_TO = 30;
   logic clk, nrst, de_req, wake_req, drive_en_pin, wake_pin;
   logic [5:0] pwm_pin;
   logic [5:0] gate_drive;
   logic [3:0] fault_cond;
   logic vdd_above_shutdown, charge_pump_active, bias_ready_flag;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic reg_wr, reg_rd, fault_out, fault_oe_n, amp_en, logic_supply_ldo;
   logic gate_bias_supply, gate_bias_from_pump, irq;
   int fails = 0;
   int checks_done = 0;

   fwpm_host i_host (.clk(clk), .nrst(nrst), .de_req(de_req), .wake_req(wake_req),
      .drive_en_pin(drive_en_pin), .wake_pin(wake_pin));

   fwpm_ctrl #(.DE_LOW_CYC(DE_LOW), .BIAS_TO_CYC(BIAS_TO)) i_dut (.clk(clk), .nrst(nrst),
      .drive_en_pin(drive_en_pin), .wake_pin(wake_pin), .pwm_pin(pwm_pin), .fault_cond(fault_cond),
      .vdd_above_shutdown(vdd_above_shutdown), .charge_pump_active(charge_pump_active),
      .bias_ready_flag(bias_ready_flag), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fault_out(fault_out), .fault_oe_n(fault_oe_n),
      .gate_drive(gate_drive), .amp_en(amp_en), .logic_supply_ldo(logic_supply_ldo),
      .gate_bias_supply(gate_bias_supply), .gate_bias_from_pump(gate_bias_from_pump), .irq(irq));

   always #4 clk = ~clk;

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic chk_rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
      logic [7:0] d;
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
      chk(d & m, exp);
   endtask

   task automatic de_set(input logic v);
      @(posedge clk);
      de_req <= v;
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_power_up();
      chk_rd(8'h01, 8'h07, 8'h01);
      chk({7'h0, fault_oe_n}, 8'h00);
      chk({7'h0, logic_supply_ldo}, 8'h00);
      chk_rd(8'h00, 8'hff, 8'h00);
      chk_rd(8'h04, 8'hff, 8'h00);
      chk_rd(8'h20, 8'hff, 8'h00);
      wr(8'h02, 8'hff);
      chk_rd(8'h02, 8'hff, 8'h00);
      @(posedge clk);
      vdd_above_shutdown <= 1'b1;
      cyc(8);
      chk({7'h0, fault_oe_n}, 8'h01);
      chk({7'h0, logic_supply_ldo}, 8'h01);
      chk_rd(8'h01, 8'h07, 8'h03);
   endtask

   task automatic t_bias_timeout();
      de_set(1'b1);
      cyc(4);
      chk_rd(8'h01, 8'h07, 8'h02);
      cyc(15);
      chk_rd(8'h01, 8'h07, 8'h02);
      cyc(15);
      chk_rd(8'h01, 8'h07, 8'h06);
      chk_rd(8'h02, 8'h08, 8'h08);
      chk({7'h0, gate_bias_supply}, 8'h01);
      @(posedge clk);
      charge_pump_active <= 1'b1;
      cyc(4);
      chk({7'h0, gate_bias_from_pump}, 8'h01);
      @(posedge clk);
      charge_pump_active <= 1'b0;
      cyc(4);
      chk({7'h0, gate_bias_from_pump}, 8'h00);
   endtask

   task automatic t_gates();
      @(posedge clk);
      pwm_pin <= 6'h2a;
      cyc(4);
      chk({2'h0, gate_drive}, 8'h2a);
      de_set(1'b0);
      cyc(13);
      chk({2'h0, gate_drive}, 8'h00);
      de_set(1'b1);
      cyc(6);
      chk_rd(8'h01, 8'h07, 8'h06);
      chk({2'h0, gate_drive}, 8'h2a);
   endtask

   task automatic t_fault();
      @(posedge clk);
      fault_cond <= 4'h4;
      cyc(4);
      chk({7'h0, fault_oe_n}, 8'h00);
      chk({7'h0, fault_out}, 8'h00);
      chk({2'h0, gate_drive}, 8'h00);
      chk_rd(8'h01, 8'h08, 8'h08);
      chk_rd(8'h02, 8'h01, 8'h01);
      wr(8'h04, 8'h01);
      cyc(1);
      chk({7'h0, irq}, 8'h01);
      de_set(1'b0);
      de_set(1'b1);
      cyc(6);
      chk({7'h0, fault_oe_n}, 8'h00);
      @(posedge clk);
      fault_cond <= 4'h0;
      cyc(6);
      chk({7'h0, fault_oe_n}, 8'h00);
      de_set(1'b0);
      de_set(1'b1);
      cyc(6);
      chk({7'h0, fault_oe_n}, 8'h01);
      wr(8'h03, 8'h01);
      cyc(1);
      chk({7'h0, irq}, 8'h00);
      wr(8'h04, 8'h00);
   endtask

   task automatic t_amp();
      wr(8'h00, 8'h01);
      de_set(1'b0);
      cyc(5);
      chk({7'h0, amp_en}, 8'h00);
      de_set(1'b1);
      cyc(5);
      chk({7'h0, amp_en}, 8'h01);
      wr(8'h00, 8'h00);
      de_set(1'b0);
      cyc(5);
      chk({7'h0, amp_en}, 8'h01);
      de_set(1'b1);
   endtask

   task automatic t_idle_modes();
      de_set(1'b0);
      cyc(30);
      chk_rd(8'h01, 8'h07, 8'h03);
      chk({7'h0, gate_bias_supply}, 8'h00);
      @(posedge clk);
      bias_ready_flag <= 1'b1;
      de_req <= 1'b1;
      cyc(8);
      chk_rd(8'h01, 8'h07, 8'h06);
      wr(8'h00, 8'h02);
      de_set(1'b0);
      cyc(30);
      chk_rd(8'h01, 8'h07, 8'h07);
      chk({7'h0, logic_supply_ldo}, 8'h00);
      chk_rd(8'h02, 8'h04, 8'h04);
   endtask

   task automatic t_wake();
      @(posedge clk);
      wake_req <= 1'b1;
      cyc(5);
      wake_req <= 1'b0;
      cyc(100);
      wake_req <= 1'b1;
      cyc(8);
      chk_rd(8'h01, 8'h07, 8'h07);
      @(posedge clk);
      wake_req <= 1'b0;
      cyc(1300);
      wake_req <= 1'b1;
      cyc(5);
      chk({7'h0, logic_supply_ldo}, 8'h01);
      chk_rd(8'h02, 8'h02, 8'h02);
   endtask

   // ----------------------------------------------------------------
   // main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      nrst = 1'b0;
      de_req = 1'b0;
      wake_req = 1'b0;
      pwm_pin = 6'h00;
      fault_cond = 4'h0;
      vdd_above_shutdown = 1'b0;
      charge_pump_active = 1'b0;
      bias_ready_flag = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      t_power_up();
      t_bias_timeout();
      t_gates();
      t_fault();
      t_amp();
      t_idle_modes();
      t_wake();
      print_verdict();
   end

   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      print_verdict();
   end
endmodule // fault_wake_power_mode_ctrl_bench
`default_nettype wire
